// file: verilog/btsd_consts.vh
// Purpose: Constants for the bit test and skip decoder
// Assumes: 16-bit instruction words, 8-bit data memory
// Notes: Phase codes are one-hot
`ifndef BTSD_CONSTS_VH
`define BTSD_CONSTS_VH
`define BTSD_OP_SKIP_SET 4'hA
`define BTSD_OP_SKIP_CLR 4'hB
`define BTSD_OP_MSB 15
`define BTSD_OP_LSB 12
`define BTSD_BIT_MSB 11
`define BTSD_BIT_LSB 9
`define BTSD_ACC_BIT 8
`define BTSD_FILE_MSB 7
`define BTSD_FILE_LSB 0
`define BTSD_IDX_LIMIT 8'h5F
`define BTSD_ACCESS_SPLIT 8'h60
`define BTSD_SKIP_ONE 2'h1
`define BTSD_SKIP_TWO 2'h2
`define BTSD_Q1 4'h1
`define BTSD_Q2 4'h2
`define BTSD_Q3 4'h4
`define BTSD_Q4 4'h8
`endif

// file: verilog/btsd_decode.v
// Purpose: Decode and execute the two bit test and skip instructions
// Assumes: One CLK edge per Q phase; fetch logic supplies the next word
// Notes: Writes nothing; a skip turns the following cycle(s) into no-ops
//
// How it works
// - Opcode 1010, bits b, access a, file f; skips when bit is one.
// - Bit set means next instruction not executed; memory never written.
// - Skip discards fetched word and runs one no-op cycle, two for a two-word one.
// - Access bit zero uses access bank, one uses bank select value.
// - Extended set, access zero, f at most 95: indexed literal offset.
// - Q1 decode, Q2 read file, Q3 process, Q4 no operation.
// - Skipping a two-word instruction inserts two full no-op cycles.
// - Skip-if-clear skips on zero and falls through on one.
// - File address spans 0 to 255; bit index is three bits.
`timescale 1ns/100ps
`include "btsd_consts.vh"

module btsd_decode #(
    parameter BANK_W = 4
) (
    input wire CLK,
    input wire RESETN,
    input wire [15:0] INSTR,
    input wire [15:0] NEXT_INSTR,
    input wire EXT_SET_EN,
    input wire [BANK_W-1:0] BANK_SELECT_VALUE,
    input wire [7:0] INDEX_BASE,
    input wire [7:0] FILE_RDATA,
    output reg [BANK_W+7:0] FILE_ADDR,
    output reg FILE_RD,
    output wire FILE_WR,
    output wire STATUS_WR,
    output reg [3:0] PHASE,
    output reg IS_BIT_TEST,
    output reg SKIP_ACTIVE,
    output reg SKIP_DONE,
    output reg [1:0] SKIP_CYCLES_LEFT
);

// --------------------------------------------------
// Field decode
// --------------------------------------------------
wire [3:0] op_code = INSTR[`BTSD_OP_MSB:`BTSD_OP_LSB];
wire [2:0] bit_index = INSTR[`BTSD_BIT_MSB:`BTSD_BIT_LSB];
wire access_sel = INSTR[`BTSD_ACC_BIT];
wire [7:0] file_field = INSTR[`BTSD_FILE_MSB:`BTSD_FILE_LSB];
wire bit_test_skip_if_set = (op_code == `BTSD_OP_SKIP_SET);
wire bit_test_skip_if_clear = (op_code == `BTSD_OP_SKIP_CLR);
wire is_test = bit_test_skip_if_set | bit_test_skip_if_clear;
// Two-word instructions start with 1100, 1110 1011 or 1110 1100/1101/1111
wire next_two_word = (NEXT_INSTR[15:12] == 4'hC) ||
    (NEXT_INSTR[15:8] == 8'hEB) || (NEXT_INSTR[15:8] == 8'hEC) ||
    (NEXT_INSTR[15:8] == 8'hED) || (NEXT_INSTR[15:8] == 8'hEF);

// --------------------------------------------------
// Effective address
// --------------------------------------------------
// Indexed mode adds the file field to the index base, low byte only
wire [7:0] idx_sum = INDEX_BASE + file_field;
wire use_banked = access_sel;
wire use_indexed = ~access_sel & EXT_SET_EN & (file_field <= `BTSD_IDX_LIMIT);
wire access_low = (file_field < `BTSD_ACCESS_SPLIT);
reg [BANK_W+7:0] addr_nxt;

always @* begin
    addr_nxt = {{BANK_W{1'b0}}, file_field};
    if (use_banked) begin
        addr_nxt = {BANK_SELECT_VALUE, file_field};
    end else if (use_indexed) begin
        addr_nxt = {{BANK_W{1'b0}}, idx_sum};
    end else if (access_low) begin
        addr_nxt = {{BANK_W{1'b0}}, file_field};
    end else begin
        // Upper access part, f from 60h to FFh, lives in the last bank
        addr_nxt = {{BANK_W{1'b1}}, file_field};
    end
end

// --------------------------------------------------
// Phase codes and state
// --------------------------------------------------
localparam [3:0] PH_Q1 = `BTSD_Q1;
localparam [3:0] PH_Q2 = `BTSD_Q2;
localparam [3:0] PH_Q3 = `BTSD_Q3;
localparam [3:0] PH_Q4 = `BTSD_Q4;

reg [3:0] phase_nxt;
reg test_r;
reg test_nxt;
reg is_bit_test_nxt;
reg [BANK_W+7:0] file_addr_nxt;
reg file_rd_nxt;
reg skip_pend_r;
reg skip_pend_nxt;
reg [1:0] skip_len_r;
reg [1:0] skip_len_nxt;
reg skip_active_nxt;
reg skip_done_nxt;
reg [1:0] skip_left_nxt;

wire tested_bit = FILE_RDATA[bit_index];
wire take_skip = bit_test_skip_if_set ? tested_bit : ~tested_bit;
wire last_noop = (SKIP_CYCLES_LEFT == `BTSD_SKIP_ONE);

// Memory and status are never written by a bit test
assign FILE_WR = 1'b0;
assign STATUS_WR = 1'b0;

// --------------------------------------------------
// Phase sequencer
// --------------------------------------------------
always @* begin
    phase_nxt = PH_Q1;
    case (PHASE)
        PH_Q1: begin
            phase_nxt = PH_Q2;
        end
        PH_Q2: begin
            phase_nxt = PH_Q3;
        end
        PH_Q3: begin
            phase_nxt = PH_Q4;
        end
        PH_Q4: begin
            phase_nxt = PH_Q1;
        end
        default: begin
            phase_nxt = PH_Q1;
        end
    endcase
end

// --------------------------------------------------
// Decode, read and test
// --------------------------------------------------
always @* begin
    test_nxt = test_r;
    is_bit_test_nxt = IS_BIT_TEST;
    file_addr_nxt = FILE_ADDR;
    file_rd_nxt = 1'b0;
    skip_pend_nxt = skip_pend_r;
    skip_len_nxt = skip_len_r;
    case (PHASE)
        PH_Q1: begin
            if (SKIP_ACTIVE) begin
                // Fetched word is dropped: no decode, no read
                test_nxt = 1'b0;
                is_bit_test_nxt = 1'b0;
            end else begin
                test_nxt = is_test;
                is_bit_test_nxt = is_test;
                file_addr_nxt = addr_nxt;
            end
        end
        PH_Q2: begin
            file_rd_nxt = test_r;
        end
        PH_Q3: begin
            if (test_r) begin
                skip_pend_nxt = take_skip;
                skip_len_nxt = next_two_word ? `BTSD_SKIP_TWO : `BTSD_SKIP_ONE;
            end else begin
                skip_pend_nxt = 1'b0;
            end
        end
        PH_Q4: begin
            // Pending skip is handed to the no-op counter here
            skip_pend_nxt = 1'b0;
        end
        default: begin
            skip_pend_nxt = 1'b0;
        end
    endcase
end

// --------------------------------------------------
// Skip no-op cycle counter
// --------------------------------------------------
always @* begin
    skip_active_nxt = SKIP_ACTIVE;
    skip_done_nxt = 1'b0;
    skip_left_nxt = SKIP_CYCLES_LEFT;
    if (PHASE == PH_Q4) begin
        if (skip_pend_r) begin
            skip_active_nxt = 1'b1;
            skip_left_nxt = skip_len_r;
        end else if (SKIP_ACTIVE) begin
            if (last_noop) begin
                skip_active_nxt = 1'b0;
                skip_done_nxt = 1'b1;
            end
            skip_left_nxt = SKIP_CYCLES_LEFT - `BTSD_SKIP_ONE;
        end
    end
end

// --------------------------------------------------
// State registers
// --------------------------------------------------
always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
        PHASE <= PH_Q1;
        test_r <= 1'b0;
        IS_BIT_TEST <= 1'b0;
        FILE_ADDR <= {(BANK_W+8){1'b0}};
        FILE_RD <= 1'b0;
        skip_pend_r <= 1'b0;
        skip_len_r <= 2'h0;
    end else begin
        PHASE <= phase_nxt;
        test_r <= test_nxt;
        IS_BIT_TEST <= is_bit_test_nxt;
        FILE_ADDR <= file_addr_nxt;
        FILE_RD <= file_rd_nxt;
        skip_pend_r <= skip_pend_nxt;
        skip_len_r <= skip_len_nxt;
    end
end

always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
        SKIP_ACTIVE <= 1'b0;
        SKIP_DONE <= 1'b0;
        SKIP_CYCLES_LEFT <= 2'h0;
    end else begin
        SKIP_ACTIVE <= skip_active_nxt;
        SKIP_DONE <= skip_done_nxt;
        SKIP_CYCLES_LEFT <= skip_left_nxt;
    end
end

endmodule // btsd_decode

// file: verif/btsd_chk.sv
// Purpose: Port checks of the bit test decoder
// Assumes: One CLK edge per phase
// Notes: Bound from tb
`timescale 1ns/100ps
module btsd_chk (
    input wire CLK,
    input wire RESETN,
    input wire [15:0] INSTR,
    input wire [7:0] FILE_RDATA,
    input wire FILE_WR,
    input wire STATUS_WR,
    input wire [3:0] PHASE,
    input wire FILE_RD,
    input wire IS_BIT_TEST,
    input wire SKIP_ACTIVE,
    input wire SKIP_DONE,
    input wire [1:0] SKIP_CYCLES_LEFT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    wire hit = INSTR[15:13] == 3'h5 && FILE_RD && PHASE == 4'h4;
    wire sk = INSTR[12] != FILE_RDATA[INSTR[11:9]];
    wire dec = PHASE == 4'h1 && !SKIP_ACTIVE;
    wire tst = INSTR[15:13] == 3'h5;
    AST_DEC: assert property (dec && tst |=> IS_BIT_TEST ##1 FILE_RD) else $error("decode");
    AST_NODEC: assert property (dec && !tst |=> !IS_BIT_TEST ##1 !FILE_RD)
        else $error("no decode");
    AST_DROP: assert property (PHASE == 4'h1 && SKIP_ACTIVE |=> !IS_BIT_TEST ##1 !FILE_RD)
        else $error("dropped word");
    AST_NOWR: assert property (!FILE_WR && !STATUS_WR) else $error("write");
    AST_PH: assert property (PHASE == 4'h1 |=> PHASE == 4'h2 ##1 PHASE == 4'h4 ##1 PHASE == 4'h8)
        else $error("phase");
    AST_RD: assert property (FILE_RD |-> PHASE == 4'h4 && !SKIP_ACTIVE) else $error("read");
    AST_SKIP: assert property (hit && sk |-> ##2 SKIP_ACTIVE) else $error("no skip");
    AST_KEEP: assert property (hit && !sk |-> ##2 !SKIP_ACTIVE) else $error("skip");
    AST_ONE: assert property ($rose(SKIP_ACTIVE) && SKIP_CYCLES_LEFT == 2'h1 |->
        SKIP_ACTIVE[*4] ##1 !SKIP_ACTIVE) else $error("one");
    AST_TWO: assert property ($rose(SKIP_ACTIVE) && SKIP_CYCLES_LEFT == 2'h2 |->
        SKIP_ACTIVE[*8] ##1 !SKIP_ACTIVE) else $error("two");
    AST_DONE: assert property ($fell(SKIP_ACTIVE) |-> SKIP_DONE ##1 !SKIP_DONE) else $error("done");
    cover property (SKIP_CYCLES_LEFT == 2'h2);
    cover property (hit && sk && INSTR[12]);
    cover property (hit && !sk);
endmodule // btsd_chk

// file: verif/tb.sv
// Purpose: Scenario bench for the bit test decoder
// Assumes: Bank width four, bank 3 then bank 5 for the last check, index base 10h
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
bind btsd_decode btsd_chk u_chk (.CLK(CLK), .RESETN(RESETN), .INSTR(INSTR),
    .FILE_RDATA(FILE_RDATA), .FILE_WR(FILE_WR), .STATUS_WR(STATUS_WR), .PHASE(PHASE),
    .FILE_RD(FILE_RD), .IS_BIT_TEST(IS_BIT_TEST), .SKIP_ACTIVE(SKIP_ACTIVE),
    .SKIP_DONE(SKIP_DONE), .SKIP_CYCLES_LEFT(SKIP_CYCLES_LEFT));
module tb;
    reg clk, resetn, ext;
    reg [15:0] instr, nxt;
    reg [7:0] rdata;
    reg [3:0] bsv;
    reg [7:0] ibase;
    wire [11:0] addr;
    wire skip;
    integer n_errors = 0, tests_run = 0, cyc = 0;
    btsd_decode u_dut (.CLK(clk), .RESETN(resetn), .INSTR(instr), .NEXT_INSTR(nxt),
        .EXT_SET_EN(ext), .BANK_SELECT_VALUE(bsv), .INDEX_BASE(ibase), .FILE_RDATA(rdata),
        .FILE_ADDR(addr), .FILE_RD(), .FILE_WR(), .STATUS_WR(), .PHASE(), .IS_BIT_TEST(),
        .SKIP_ACTIVE(skip), .SKIP_DONE(), .SKIP_CYCLES_LEFT());
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            conclude;
        end
    end
    task conclude;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task run(input [15:0] i, input [15:0] n, input [7:0] d, input integer k, input [11:0] a);
        integer m;
        instr = i;
        nxt = n;
        rdata = d;
        repeat (4) @(posedge clk);
        #1 m = 0;
        while (skip === 1'b1 && m < 20) begin
            @(posedge clk);
            #1 m++;
        end
        tests_run++;
        if (addr !== a || m != 4 * k) begin
            n_errors++;
            $display("CHECK FAILED %0t addr %h skip %0d", $time, addr, m);
        end
    endtask
    task t_set;
        run(16'hAE20, 16'h0000, 8'h80, 1, 12'h020);
        run(16'hAE20, 16'hC000, 8'h80, 2, 12'h020);
        run(16'hAFFF, 16'hC000, 8'h7F, 0, 12'h3FF);
        run(16'h9E20, 16'h0000, 8'h80, 0, 12'h020);
    endtask
    task t_clr;
        run(16'hB060, 16'hEF00, 8'hFE, 2, 12'hF60);
        run(16'hB060, 16'h0000, 8'h01, 0, 12'hF60);
    endtask
    task t_idx;
        ext = 1'b1;
        run(16'hA25F, 16'h0000, 8'h00, 0, 12'h06F);
        run(16'hA260, 16'h0000, 8'h02, 1, 12'hF60);
        bsv = 4'h5;
        run(16'hA110, 16'h0000, 8'h01, 1, 12'h510);
    endtask
    initial begin
        resetn = 1'b0;
        ext = 1'b0;
        instr = 16'h0000;
        nxt = 16'h0000;
        rdata = 8'h00;
        bsv = 4'h3;
        ibase = 8'h10;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        t_set;
        t_clr;
        t_idx;
        conclude;
    end
endmodule // tb
